//--- dv/scp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module scp_host_model
(
  // serial pins driven by the host
  output logic      port_select_n,
  output logic      serial_clk,
  output logic      host_drv,
  // lines read back by the host
  input  wire logic sdio_wire,
  input  wire logic serial_out,
  input  wire logic four_wire
);
  initial
  begin
    port_select_n = 1'b1;
    serial_clk    = 1'b0;
    host_drv      = 1'b0;
  end

  // n below 16 cuts a frame short; hold keeps select low for chaining
  task automatic frame(input logic [15:0] w, input int n, input bit hold,
                       output logic [7:0] rd);
    rd = 8'h00;
    port_select_n = 1'b0;
    for (int i = 15; i >= 16 - n; i--)
    begin
      // released line toggles so a stale level never passes for data
      host_drv = (i < 8 && !w[15]) ? ~host_drv : w[i];
      #40 serial_clk = 1'b1;
      if (i < 8)
        rd[i] = four_wire ? serial_out : sdio_wire;
      #40 serial_clk = 1'b0;
    end
    if (!hold)
    begin
      #40 port_select_n = 1'b1;
      #120;
    end
  endtask
endmodule
`default_nettype wire

//--- dv/scp_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module scp_top_assertions
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // serial pins
  input wire logic       port_select_n,
  input wire logic       sdio_oe_n,
  input wire logic       serial_out,
  // register fields
  input wire logic       port_wiring_select,
  input wire logic [5:0] dc_preset,
  input wire logic       cal_start_cmd,
  input wire logic       cal_modules_reset_n,
  input wire logic       modulator_soft_reset_n,
  input wire logic       top_enable,
  input wire logic       transmit_enable,
  input wire logic       forced_code_mode,
  input wire logic       filter_cal_reset,
  input wire logic       filter_cal_clock_select,
  input wire logic [2:0] forced_cal_code,
  input wire logic [3:0] filter_bandwidth_code,
  input wire logic [2:0] rc_cal_result,
  input wire logic [3:0] rf_loop_path
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // cycles the calibration reset has been high, saturating
  logic [4:0] rst_hi_q;
  always_ff @(posedge clk)
  begin
    if (reset || !filter_cal_reset)
      rst_hi_q <= 5'h00;
    else if (rst_hi_q != 5'h1f)
      rst_hi_q <= rst_hi_q + 5'h01;
  end

  rst_ctrl_a: assert property ($fell(reset) |-> dc_preset == 6'h1f
    && !cal_start_cmd && cal_modules_reset_n && modulator_soft_reset_n
    && top_enable && !transmit_enable && port_wiring_select)
    else $error("control fields wrong after reset");
  rst_fcal_a: assert property ($fell(reset) |-> filter_cal_reset
    && filter_cal_clock_select && !forced_code_mode
    && filter_bandwidth_code == 4'h0 && rf_loop_path == 4'h0)
    else $error("calibration fields wrong after reset");
  oe_wiring_a: assert property (!sdio_oe_n |-> !port_wiring_select)
    else $error("shared pin driven in four-wire mode");
  out_wiring_a: assert property (!port_wiring_select |-> !serial_out)
    else $error("serial out active in three-wire mode");
  idle_pins_a: assert property (port_select_n [*8] |-> sdio_oe_n && !serial_out)
    else $error("read data driven while deselected");
  idle_cfg_a: assert property (port_select_n [*8] |=> $stable({dc_preset,
    cal_start_cmd, top_enable, port_wiring_select, forced_cal_code,
    filter_bandwidth_code, rf_loop_path}))
    else $error("register changed while deselected");
  forced_rc_a: assert property (forced_code_mode && $past(forced_code_mode)
    && $stable(forced_cal_code) |-> rc_cal_result == forced_cal_code)
    else $error("forced code not passed to rc result");
  fcal_hold_a: assert property ($fell(filter_cal_reset) |-> rst_hi_q >= 5'h0a)
    else $error("calibration reset too short");
  oe_select_a: assert property ($fell(sdio_oe_n) |-> !port_select_n)
    else $error("read turnaround without select");

  cover property ($fell(sdio_oe_n));
  cover property ($fell(filter_cal_reset));
  cover property (forced_code_mode && rc_cal_result == forced_cal_code);
endmodule

bind scp_top scp_top_assertions i_chk (.clk, .reset, .port_select_n,
  .sdio_oe_n, .serial_out, .port_wiring_select, .dc_preset, .cal_start_cmd,
  .cal_modules_reset_n, .modulator_soft_reset_n, .top_enable,
  .transmit_enable, .forced_code_mode, .filter_cal_reset,
  .filter_cal_clock_select, .forced_cal_code, .filter_bandwidth_code,
  .rc_cal_result, .rf_loop_path);
`default_nettype wire

//--- dv/scp_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module scp_top_tb;
  logic       clk, reset, ce, host_drv, four_wire, sdio_in;
  logic       port_select_n, serial_clk, sdio_out, sdio_oe_n, serial_out;
  logic       cal_in_progress, comparator_direction, filter_cal_reset;
  logic [5:0] dc_module_value, dc_preset;
  logic [2:0] rc_cal_calibrated, lock_pattern, rc_cal_result;
  logic [3:0] rf_loop_path;
  int         miscompares = 0;
  int         checked = 0;

  // resolved shared data wire
  assign sdio_in = sdio_oe_n ? host_drv : sdio_out;

  scp_top i_dut (.clk, .reset, .ce, .port_select_n, .serial_clk, .sdio_in,
    .sdio_out, .sdio_oe_n, .serial_out, .dc_module_value, .rc_cal_calibrated,
    .lock_pattern, .cal_in_progress, .comparator_direction, .dc_preset,
    .cal_start_cmd(), .preset_load_cmd(), .cal_modules_reset_n(),
    .cal_module_select(), .decode_test_select(), .modulator_soft_reset_n(),
    .top_enable(), .transmit_enable(), .receive_enable(),
    .port_wiring_select(), .filter_cal_clock_select(),
    .filter_cal_clock_powerdown(), .forced_code_mode(), .filter_cal_reset,
    .filter_cal_enable(), .forced_cal_code(), .filter_bandwidth_code(),
    .rc_cal_result, .bb_loop_to_filter(), .bb_loop_to_gain_stage(),
    .bb_loop_to_pins(), .rf_loop_path);

  scp_host_model i_host (.port_select_n, .serial_clk, .host_drv,
    .sdio_wire(sdio_in), .serial_out, .four_wire);

  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input bit h);
    logic [7:0] v;
    i_host.frame({1'b1, a, d}, 16, h, v);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_host.frame({1'b0, a, 8'h00}, 16, 1'b0, v);
    check($sformatf("register %h", a), v, exp);
  endtask

  task automatic t_reset_values();
    logic [7:0] exp [9] = '{8'h2a, 8'haf, 8'h1f, 8'h08, 8'h10, 8'h32,
                            8'h0d, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++)
      rd_chk(7'(i), exp[i]);
  endtask

  task automatic t_write_all();
    logic [6:0] a   [6] = '{7'h02, 7'h03, 7'h05, 7'h06, 7'h07, 7'h08};
    logic [7:0] exp [6] = '{8'h3f, 8'h3f, 8'hbe, 8'h0f, 8'hff, 8'h7f};
    logic [7:0] v;
    for (int i = 0; i < 6; i++)
      wr(a[i], 8'hff, i < 5);
    for (int i = 0; i < 6; i++)
      rd_chk(a[i], exp[i]);
    check("preset pins", {2'b00, dc_preset}, 8'h3f);
    check("rf loop pins", {4'h0, rf_loop_path}, 8'h0f);
    check("rc result", {5'h00, rc_cal_result}, 8'h07);
    wr(7'h00, 8'hff, 1'b1);
    wr(7'h04, 8'h00, 1'b1);
    wr(7'h09, 8'hff, 1'b1);
    wr(7'h10, 8'hff, 1'b0);
    rd_chk(7'h00, 8'h2a);
    rd_chk(7'h04, 8'h10);
    rd_chk(7'h09, 8'h00);
    rd_chk(7'h10, 8'h00);
    // one clock short of a frame must leave the register alone
    i_host.frame({1'b1, 7'h08, 8'h55}, 15, 1'b0, v);
    rd_chk(7'h08, 8'h7f);
    wr(7'h03, 8'h08, 1'b0);
    wr(7'h07, 8'h00, 1'b0);
    rd_chk(7'h03, 8'h08);
  endtask

  task automatic t_three_wire();
    wr(7'h05, 8'h30, 1'b0);
    four_wire = 1'b0;
    rd_chk(7'h05, 8'h30);
    rd_chk(7'h00, 8'h2a);
    wr(7'h05, 8'h32, 1'b0);
    four_wire = 1'b1;
    rd_chk(7'h05, 8'h32);
  endtask

  task automatic t_fcal_reset();
    int n;
    wr(7'h06, 8'h0c, 1'b0);
    n = 0;
    while (filter_cal_reset !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    check("cal reset low", {7'h00, filter_cal_reset}, 8'h00);
    wr(7'h06, 8'h0d, 1'b0);
    check("cal reset high", {7'h00, filter_cal_reset}, 8'h01);
  endtask

  task automatic end_sim();
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    four_wire = 1'b1;
    dc_module_value = 6'h2a;
    rc_cal_calibrated = 3'h5;
    lock_pattern = 3'h3;
    cal_in_progress = 1'b1;
    comparator_direction = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    t_reset_values();
    t_write_all();
    t_three_wire();
    t_fcal_reset();
    end_sim();
  end

  // about 40 frames of up to 1.44 us each, with ample margin
  initial
  begin
    #300_000;
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire

//--- hdl/scp_pkg.sv
// Overview of operation
// - a write frame is exactly 16 serial clocks; the byte commits after the last.
// - a read frame is 16 clocks: 8 instruction in, 8 data bits out.
// - select is active low; back-to-back frames decode as new accesses.
// - frame is an 8-bit instruction then 8 data bits; registers are 8 bits.
// - first instruction bit is the access type: 1 write, 0 read.
// - then 3 block address bits and 4 register index bits.
// - three-wire reads drive the shared pin; four-wire reads use serial_out.
// - eight blocks by 3-bit address; only the top block lives here.
// - bit 1 of 0x05 picks wiring: 0 three-wire, 1 four-wire default.
// - 0x05 resets to 0x32 with decode, soft reset and enable fields.
// - 0x00 is read-only, bits 5..0 give the selected calibration value.
// - 0x01 gives rc result, lock pattern and calibration-in-progress.
// - bit 0 of 0x01 shows comparator direction, 1 up, 0 down.
// - 0x02 bits 5..0 hold the preset value; reset 0x1f.
// - 0x03 bits 5 and 4 are start and load commands, software clears.
// - 0x03 bit 3 is active-low calibration reset; register resets 0x08.
// - 0x03 bits 2..0 select the calibration module; only 000 defined.
// - 0x04 is read-only: generation in 7..4, step in 3..0.
// - 0x06 resets 0x0d; clock select, powerdown, reset held over 100 ns.
// - with forced mode set, the forced code replaces the rc result.
// - 0x07 resets 0; bit 7 enables calibration, 3..0 bandwidth code.
// - 0x08 resets 0; bits 6..4 baseband loops, 3..0 rf loop path.
package scp_pkg;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned INST_BITS  = 8;
  localparam logic [4:0]  CNT_INST   = 5'h07;
  localparam logic [4:0]  CNT_LAST   = 5'h0f;

  localparam int unsigned BIT_RW     = 7;
  localparam int unsigned BLK_HI     = 6;
  localparam int unsigned BLK_LO     = 4;
  localparam int unsigned IDX_HI     = 3;
  localparam logic [2:0]  BLK_TOP    = 3'h0;

  localparam logic [3:0] IDX_DC_READBACK = 4'h0;
  localparam logic [3:0] IDX_CAL_STATUS  = 4'h1;
  localparam logic [3:0] IDX_DC_PRESET   = 4'h2;
  localparam logic [3:0] IDX_DC_COMMAND  = 4'h3;
  localparam logic [3:0] IDX_CHIP_ID     = 4'h4;
  localparam logic [3:0] IDX_TOP_CONTROL = 4'h5;
  localparam logic [3:0] IDX_FCAL_CLOCK  = 4'h6;
  localparam logic [3:0] IDX_FCAL_BW     = 4'h7;
  localparam logic [3:0] IDX_LOOPBACK    = 4'h8;

  localparam logic [7:0] RST_DC_PRESET   = 8'h1f;
  localparam logic [7:0] RST_DC_COMMAND  = 8'h08;
  localparam logic [7:0] RST_TOP_CONTROL = 8'h32;
  localparam logic [7:0] RST_FCAL_CLOCK  = 8'h0d;
  localparam logic [7:0] RST_FCAL_BW     = 8'h00;
  localparam logic [7:0] RST_LOOPBACK    = 8'h00;

  // writable bits; everything else stays zero
  localparam logic [7:0] MSK_DC_PRESET   = 8'h3f;
  localparam logic [7:0] MSK_DC_COMMAND  = 8'h3f;
  localparam logic [7:0] MSK_TOP_CONTROL = 8'hbe;
  localparam logic [7:0] MSK_FCAL_CLOCK  = 8'h0f;
  localparam logic [7:0] MSK_FCAL_BW     = 8'hff;
  localparam logic [7:0] MSK_LOOPBACK    = 8'h7f;

  // field positions
  localparam int unsigned CMD_START   = 5;
  localparam int unsigned CMD_LOAD    = 4;
  localparam int unsigned CMD_RESET_N = 3;
  localparam int unsigned TOP_DECODE  = 7;
  localparam int unsigned TOP_MOD_RN  = 5;
  localparam int unsigned TOP_EN      = 4;
  localparam int unsigned TOP_TX_EN   = 3;
  localparam int unsigned TOP_RX_EN   = 2;
  localparam int unsigned TOP_WIRING  = 1;
  localparam int unsigned FC_CLKSEL   = 3;
  localparam int unsigned FC_PD       = 2;
  localparam int unsigned FC_FORCE    = 1;
  localparam int unsigned FC_RESET    = 0;
  localparam int unsigned BW_ENABLE   = 7;
  localparam int unsigned LB_FILTER   = 6;
  localparam int unsigned LB_GAIN     = 5;
  localparam int unsigned LB_PINS     = 4;

  // least hold of the filter calibration reset
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned FCAL_RST_MIN_NS = 100;
  localparam int unsigned FCAL_RST_CYC =
    (FCAL_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  FCAL_RST_CNT = 5'(FCAL_RST_CYC);
endpackage

//--- hdl/scp_top.sv
`timescale 1ns/10ps
`default_nettype none
module scp_top
#(
  // arbitrary identity values, not those of any product
  parameter logic [3:0] SILICON_GENERATION = 4'h1,
  parameter logic [3:0] SILICON_STEP       = 4'h0
)
(
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // serial port pins
  input  wire logic       port_select_n,
  input  wire logic       serial_clk,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_n,
  output logic            serial_out,
  // calibration status from the analog side
  input  wire logic [5:0] dc_module_value,
  input  wire logic [2:0] rc_cal_calibrated,
  input  wire logic [2:0] lock_pattern,
  input  wire logic       cal_in_progress,
  input  wire logic       comparator_direction,
  // calibration control
  output logic [5:0]      dc_preset,
  output logic            cal_start_cmd,
  output logic            preset_load_cmd,
  output logic            cal_modules_reset_n,
  output logic [2:0]      cal_module_select,
  // top control
  output logic            decode_test_select,
  output logic            modulator_soft_reset_n,
  output logic            top_enable,
  output logic            transmit_enable,
  output logic            receive_enable,
  output logic            port_wiring_select,
  // filter calibration
  output logic            filter_cal_clock_select,
  output logic            filter_cal_clock_powerdown,
  output logic            forced_code_mode,
  output logic            filter_cal_reset,
  output logic            filter_cal_enable,
  output logic [2:0]      forced_cal_code,
  output logic [3:0]      filter_bandwidth_code,
  output logic [2:0]      rc_cal_result,
  // loopback
  output logic            bb_loop_to_filter,
  output logic            bb_loop_to_gain_stage,
  output logic            bb_loop_to_pins,
  output logic [3:0]      rf_loop_path
);

  // pin synchronisers
  logic [2:0] sclk_q;
  logic [1:0] sel_n_q;
  logic [1:0] din_q;
  logic [5:0] dcv_q1;
  logic [5:0] dcv_q2;
  logic [6:0] st_q1;
  logic [6:0] st_q2;
  logic       cmp_q1;
  logic       cmp_q2;

  // frame state
  logic [4:0] cnt_q;
  logic [6:0] shift_q;
  logic [7:0] inst_q;
  logic [7:0] tx_q;
  logic       out_q;
  logic       drive_q;

  // registers
  logic [7:0] dc_preset_q;
  logic [7:0] dc_command_q;
  logic [7:0] top_control_q;
  logic [7:0] fcal_clock_q;
  logic [7:0] fcal_bw_q;
  logic [7:0] loopback_q;
  logic [4:0] rst_hold_q;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       selected;
  logic [7:0] inst_d;
  logic [7:0] wdata_d;
  logic       wr_stb;
  logic [7:0] rdata_d;
  logic [2:0] rc_sel_d;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_q  <= 3'h0;
      sel_n_q <= 2'h3;
      din_q   <= 2'h0;
    end
    else if (ce)
    begin
      sclk_q  <= {sclk_q[1:0], serial_clk};
      sel_n_q <= {sel_n_q[0], port_select_n};
      din_q   <= {din_q[0], sdio_in};
    end
  end

  // status is asynchronous to clk; a multi-bit word may tear for one cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dcv_q1 <= 6'h00;
      dcv_q2 <= 6'h00;
      st_q1  <= 7'h00;
      st_q2  <= 7'h00;
      cmp_q1 <= 1'b0;
      cmp_q2 <= 1'b0;
    end
    else if (ce)
    begin
      dcv_q1 <= dc_module_value;
      dcv_q2 <= dcv_q1;
      st_q1  <= {rc_cal_calibrated, lock_pattern, cal_in_progress};
      st_q2  <= st_q1;
      // comparator is an analog-side pin as well, so it gets two stages
      cmp_q1 <= comparator_direction;
      cmp_q2 <= cmp_q1;
    end
  end

  // edges seen only between the second and third stage
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign selected  = ~sel_n_q[1];
  assign inst_d    = {shift_q, din_q[1]};
  assign wdata_d   = {shift_q, din_q[1]};
  assign wr_stb    = selected & sclk_rise & (cnt_q == scp_pkg::CNT_LAST)
                     & inst_q[scp_pkg::BIT_RW]
                     & (inst_q[scp_pkg::BLK_HI:scp_pkg::BLK_LO]
                        == scp_pkg::BLK_TOP);

  // bit counter and input shift, msb first
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q   <= 5'h00;
      shift_q <= 7'h00;
    end
    else if (ce)
    begin
      if (!selected)
      begin
        cnt_q <= 5'h00;
      end
      else if (sclk_rise)
      begin
        shift_q <= {shift_q[5:0], din_q[1]};
        if (cnt_q == scp_pkg::CNT_LAST)
        begin
          cnt_q <= 5'h00;
        end
        else
        begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // instruction capture after eight bits
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      inst_q <= 8'h00;
    end
    else if (ce && selected && sclk_rise && cnt_q == scp_pkg::CNT_INST)
    begin
      inst_q <= inst_d;
    end
  end

  // forced code replaces the calibrated result
  assign rc_sel_d = fcal_clock_q[scp_pkg::FC_FORCE] ? fcal_bw_q[6:4]
                                                     : st_q2[6:4];

  always_comb
  begin
    rdata_d = 8'h00;
    if (inst_d[scp_pkg::BLK_HI:scp_pkg::BLK_LO] == scp_pkg::BLK_TOP)
    begin
      case (inst_d[scp_pkg::IDX_HI:0])
        scp_pkg::IDX_DC_READBACK: rdata_d = {2'h0, dcv_q2};
        scp_pkg::IDX_CAL_STATUS:
          rdata_d = {rc_sel_d, st_q2[3:0], cmp_q2};
        scp_pkg::IDX_DC_PRESET:   rdata_d = dc_preset_q;
        scp_pkg::IDX_DC_COMMAND:  rdata_d = dc_command_q;
        scp_pkg::IDX_CHIP_ID:
          rdata_d = {SILICON_GENERATION, SILICON_STEP};
        scp_pkg::IDX_TOP_CONTROL: rdata_d = top_control_q;
        scp_pkg::IDX_FCAL_CLOCK:  rdata_d = fcal_clock_q;
        scp_pkg::IDX_FCAL_BW:     rdata_d = fcal_bw_q;
        scp_pkg::IDX_LOOPBACK:    rdata_d = loopback_q;
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  // read data loads at the eighth rising edge, leaves on falling edges
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_q    <= 8'h00;
      out_q   <= 1'b0;
      drive_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!selected)
      begin
        drive_q <= 1'b0;
      end
      else if (sclk_rise && cnt_q == scp_pkg::CNT_INST)
      begin
        drive_q <= ~inst_d[scp_pkg::BIT_RW];
        tx_q    <= rdata_d;
        out_q   <= rdata_d[7];
      end
      else if (sclk_rise && cnt_q == scp_pkg::CNT_LAST)
      begin
        drive_q <= 1'b0;
      end
      else if (sclk_fall && drive_q)
      begin
        out_q <= tx_q[7];
        tx_q  <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // three-wire drives the shared pin, four-wire the dedicated output
  assign sdio_out   = out_q;
  assign sdio_oe_n  = ~(drive_q & ~top_control_q[scp_pkg::TOP_WIRING]);
  assign serial_out = out_q & drive_q
                      & top_control_q[scp_pkg::TOP_WIRING];

  // calibration preset and command
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dc_preset_q  <= scp_pkg::RST_DC_PRESET;
      dc_command_q <= scp_pkg::RST_DC_COMMAND;
    end
    else if (ce && wr_stb)
    begin
      if (inst_q[scp_pkg::IDX_HI:0] == scp_pkg::IDX_DC_PRESET)
      begin
        dc_preset_q <= wdata_d & scp_pkg::MSK_DC_PRESET;
      end
      if (inst_q[scp_pkg::IDX_HI:0] == scp_pkg::IDX_DC_COMMAND)
      begin
        dc_command_q <= wdata_d & scp_pkg::MSK_DC_COMMAND;
      end
    end
  end

  // top control and loopback
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      top_control_q <= scp_pkg::RST_TOP_CONTROL;
      loopback_q    <= scp_pkg::RST_LOOPBACK;
    end
    else if (ce && wr_stb)
    begin
      if (inst_q[scp_pkg::IDX_HI:0] == scp_pkg::IDX_TOP_CONTROL)
      begin
        top_control_q <= wdata_d & scp_pkg::MSK_TOP_CONTROL;
      end
      if (inst_q[scp_pkg::IDX_HI:0] == scp_pkg::IDX_LOOPBACK)
      begin
        loopback_q <= wdata_d & scp_pkg::MSK_LOOPBACK;
      end
    end
  end

  // filter calibration registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fcal_clock_q <= scp_pkg::RST_FCAL_CLOCK;
      fcal_bw_q    <= scp_pkg::RST_FCAL_BW;
    end
    else if (ce && wr_stb)
    begin
      if (inst_q[scp_pkg::IDX_HI:0] == scp_pkg::IDX_FCAL_CLOCK)
      begin
        fcal_clock_q <= wdata_d & scp_pkg::MSK_FCAL_CLOCK;
      end
      if (inst_q[scp_pkg::IDX_HI:0] == scp_pkg::IDX_FCAL_BW)
      begin
        fcal_bw_q <= wdata_d & scp_pkg::MSK_FCAL_BW;
      end
    end
  end

  // stretch a short calibration reset so the analog block sees 100 ns
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rst_hold_q <= scp_pkg::FCAL_RST_CNT;
    end
    else if (ce)
    begin
      if (fcal_clock_q[scp_pkg::FC_RESET])
      begin
        rst_hold_q <= scp_pkg::FCAL_RST_CNT;
      end
      else if (rst_hold_q != 5'h00)
      begin
        rst_hold_q <= rst_hold_q - 5'h01;
      end
    end
  end

  // field outputs from flip-flops; filter_cal_reset and rc_cal_result pass through logic
  assign dc_preset                  = dc_preset_q[5:0];
  assign cal_start_cmd              = dc_command_q[scp_pkg::CMD_START];
  assign preset_load_cmd            = dc_command_q[scp_pkg::CMD_LOAD];
  assign cal_modules_reset_n        = dc_command_q[scp_pkg::CMD_RESET_N];
  assign cal_module_select          = dc_command_q[2:0];
  assign decode_test_select         = top_control_q[scp_pkg::TOP_DECODE];
  assign modulator_soft_reset_n     = top_control_q[scp_pkg::TOP_MOD_RN];
  assign top_enable                 = top_control_q[scp_pkg::TOP_EN];
  assign transmit_enable            = top_control_q[scp_pkg::TOP_TX_EN];
  assign receive_enable             = top_control_q[scp_pkg::TOP_RX_EN];
  assign port_wiring_select         = top_control_q[scp_pkg::TOP_WIRING];
  assign filter_cal_clock_select    = fcal_clock_q[scp_pkg::FC_CLKSEL];
  assign filter_cal_clock_powerdown = fcal_clock_q[scp_pkg::FC_PD];
  assign forced_code_mode           = fcal_clock_q[scp_pkg::FC_FORCE];
  assign filter_cal_reset           = fcal_clock_q[scp_pkg::FC_RESET]
                                      | (rst_hold_q != 5'h00);
  assign filter_cal_enable          = fcal_bw_q[scp_pkg::BW_ENABLE];
  assign forced_cal_code            = fcal_bw_q[6:4];
  assign filter_bandwidth_code      = fcal_bw_q[3:0];
  assign rc_cal_result              = rc_sel_d;
  assign bb_loop_to_filter          = loopback_q[scp_pkg::LB_FILTER];
  assign bb_loop_to_gain_stage      = loopback_q[scp_pkg::LB_GAIN];
  assign bb_loop_to_pins            = loopback_q[scp_pkg::LB_PINS];
  assign rf_loop_path               = loopback_q[3:0];

endmodule
`default_nettype wire
